// ---- core/adc_output_port.sv ----
// output side of the sampling converter: pipeline, buffer and pin drive
// ************************************************
// Behaviour
// - outputs change only at rising clock edge
// - enable high puts code and flag high-Z
// - code is unsigned straight binary
// - flag high at and above full scale plus one step
// - code saturates all ones while flag high
// - only rising edges used, duty independent
// - bit zero is least significant bit
// - word appears twelve clocks after sampling, thirteen from the first stall until the next reset
// ************************************************
`timescale 1ns/1ps
`include "adc_output_port_defs.svh"
module adc_output_port (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// quantised sample from the converter core, one per clock
	input  wire logic [`CODE_WIDTH:0]   rawLevel,
	// output control pin, active low
	input  wire logic                   outEnable_n,
	// receiver ready, low stalls the port
	input  wire logic                   sinkReady,
	// data pins
	output logic [`CODE_WIDTH-1:0]      sampleCodeBits,
	output logic [`CODE_WIDTH-1:0]      sampleCodeOe,
	output logic                        overrangeFlag,
	output logic                        overrangeOe,
	output logic                        wordValidStrobe,
	output logic                        calDone
);
	// ************************************************
	// saturation function
	// ************************************************
	// levels above the top code set the flag and clamp the code
	function automatic adc_output_port_pkg::out_word_t encode(input logic [`CODE_WIDTH:0] lvl);
		adc_output_port_pkg::out_word_t w;
		w.overrangeFlag  = lvl > {1'b0, `CODE_MAX};
		w.sampleCodeBits = w.overrangeFlag ? `CODE_MAX : lvl[`CODE_MSB_POS:`CODE_LSB_POS];
		return w;
	endfunction

	// ************************************************
	// enable pin synchroniser
	// ************************************************
	logic [2:0] enSync_reg, enSync_next;
	logic       enState_reg, enState_next;
	// three stages, a change counts once stages two and three agree
	always_comb begin
		enSync_next  = {enSync_reg[1:0], outEnable_n};
		enState_next = enState_reg;
		if (enSync_reg[2] == enSync_reg[1]) begin
			enState_next = enSync_reg[2];
		end
	end
	// reset to the released level, so the pins stay high-Z until the pin has settled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enSync_reg  <= 3'h7;
			enState_reg <= 1'b1;
		end else begin
			enSync_reg  <= enSync_next;
			enState_reg <= enState_next;
		end
	end

	// ************************************************
	// latency pipeline
	// ************************************************
	// a sample registered at edge N passes PIPE_N stages, one buffer slot and the
	// output register, so its word is launched at edge N plus twelve
	localparam int PIPE_N = `LATENCY_CYCLES - 1;
	adc_output_port_pkg::out_word_t pipe_reg [PIPE_N], pipe_next [PIPE_N];
	logic [PIPE_N-1:0] pipeV_reg, pipeV_next;
	logic              pipeAdvance;
	always_comb begin
		for (int i = 0; i < PIPE_N; i++) begin
			pipe_next[i] = pipe_reg[i];
		end
		pipeV_next = pipeV_reg;
		if (pipeAdvance) begin
			pipe_next[0] = encode(rawLevel);
			for (int i = 1; i < PIPE_N; i++) begin
				pipe_next[i] = pipe_reg[i-1];
			end
			pipeV_next = {pipeV_reg[PIPE_N-2:0], 1'b1};
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < PIPE_N; i++) begin
				pipe_reg[i] <= '0;
			end
			pipeV_reg <= '0;
		end else begin
			for (int i = 0; i < PIPE_N; i++) begin
				pipe_reg[i] <= pipe_next[i];
			end
			pipeV_reg <= pipeV_next;
		end
	end

	// ************************************************
	// two-entry buffer
	// ************************************************
	// limitation: a stall leaves both slots filled, and since words leave no faster
	// than they arrive, the extra slot adds one clock of latency until the next reset
	adc_output_port_pkg::out_word_t buf_reg [2], buf_next [2];
	logic [1:0] bufCnt_reg, bufCnt_next;
	logic       inValid, outTake, bufReady, inPush;
	// one-bit event to a count step for the occupancy arithmetic
	function automatic logic [1:0] step(input logic ev);
		return ev ? 2'h1 : 2'h0;
	endfunction
	assign inValid     = pipeV_reg[PIPE_N-1];
	assign inPush      = inValid && bufReady; // word moves from pipe into buffer
	assign bufReady    = (bufCnt_reg != 2'h2) || outTake;
	assign pipeAdvance = bufReady; // back-pressure stalls the pipeline
	assign outTake     = (bufCnt_reg != 2'h0) && sinkReady;
	// entry 0 is the head; push behind, pop shifts
	always_comb begin
		buf_next[0] = buf_reg[0];
		buf_next[1] = buf_reg[1];
		bufCnt_next = bufCnt_reg;
		if (outTake) begin
			buf_next[0] = buf_reg[1];
		end
		if (inPush) begin
			// slot index is 0 or 1: a full buffer only accepts while it pops
			buf_next[1'(bufCnt_reg - step(outTake))] = pipe_reg[PIPE_N-1];
		end
		bufCnt_next = bufCnt_reg + step(inPush) - step(outTake);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			bufCnt_reg <= 2'h0;
		end else begin
			buf_reg[0] <= buf_next[0];
			buf_reg[1] <= buf_next[1];
			bufCnt_reg <= bufCnt_next;
		end
	end

	// ************************************************
	// output registers and pin enables
	// ************************************************
	adc_output_port_pkg::out_word_t word_reg, word_next;
	logic strobe_reg, strobe_next;
	logic oe_reg, oe_next;
	// word changes only on a rising edge, held for the full period;
	// the strobe is registered beside it so both reach the pins on one edge
	// and the pin enable is registered so every enable comes from a flop
	always_comb begin
		word_next   = outTake ? buf_reg[0] : word_reg;
		strobe_next = outTake;
		oe_next     = ~enState_reg;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_reg   <= '0;
			strobe_reg <= 1'b0;
			oe_reg     <= 1'b0;
		end else begin
			word_reg   <= word_next;
			strobe_reg <= strobe_next;
			oe_reg     <= oe_next;
		end
	end
	assign sampleCodeBits  = word_reg.sampleCodeBits;
	assign overrangeFlag   = word_reg.overrangeFlag;
	assign sampleCodeOe    = {`CODE_WIDTH{oe_reg}};
	assign overrangeOe     = oe_reg;
	assign wordValidStrobe = strobe_reg;

	// ************************************************
	// calibration warm-up counter
	// ************************************************
	adc_output_port_pkg::cal_state_t calSt_reg, calSt_next;
	logic [`CAL_CNT_W-1:0] calCnt_reg, calCnt_next;
	logic                  calDone_reg, calDone_next;
	// counts rising edges after reset, flags when codes are trustworthy
	// the count stops once done, so it never wraps back to running
	always_comb begin
		calSt_next   = calSt_reg;
		calCnt_next  = calCnt_reg;
		calDone_next = calDone_reg;
		case (calSt_reg)
			adc_output_port_pkg::CAL_RUN: begin
				calCnt_next = calCnt_reg + 1'b1;
				if (calCnt_reg == `CAL_CNT_W'(`CAL_CYCLES - 1)) begin
					calSt_next   = adc_output_port_pkg::CAL_DONE;
					calDone_next = 1'b1;
				end
			end
			adc_output_port_pkg::CAL_DONE: begin
				calDone_next = 1'b1;
			end
			default: begin
				calSt_next = adc_output_port_pkg::CAL_RUN;
			end
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			calSt_reg   <= adc_output_port_pkg::CAL_RUN;
			calCnt_reg  <= '0;
			calDone_reg <= 1'b0;
		end else begin
			calSt_reg   <= calSt_next;
			calCnt_reg  <= calCnt_next;
			calDone_reg <= calDone_next;
		end
	end
	assign calDone = calDone_reg;
endmodule // adc_output_port

// ---- core/adc_output_port_defs.svh ----
// timing and format constants of the converter output port
`ifndef ADC_OUTPUT_PORT_DEFS_SVH
`define ADC_OUTPUT_PORT_DEFS_SVH
`define CODE_WIDTH        10
`define CODE_MAX          10'h3FF
`define CODE_LSB_POS      0
`define CODE_MSB_POS      9
`define LATENCY_CYCLES    12
`define CAL_CYCLES        10000
`define LAT_CNT_W         4
`define CAL_CNT_W         14
`endif

// ---- core/adc_output_port_pkg.sv ----
// types of the converter output port
`include "adc_output_port_defs.svh"
package adc_output_port_pkg;
	// one converted word: code plus overrange flag
	typedef struct packed {
		logic                     overrangeFlag;
		logic [`CODE_WIDTH-1:0]   sampleCodeBits;
	} out_word_t;
	typedef enum logic [1:0] {CAL_RUN, CAL_DONE} cal_state_t;
endpackage

// ---- sim/adc_output_port_props.sv ----
// pin assertions of the converter output port
`timescale 1ns/1ps
module adc_output_port_props (
	// clock, reset and inputs
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [10:0] rawLevel,
	input wire logic        outEnable_n,
	input wire logic        sinkReady,
	// outputs
	input wire logic [9:0]  sampleCodeBits,
	input wire logic [9:0]  sampleCodeOe,
	input wire logic        overrangeFlag,
	input wire logic        overrangeOe,
	input wire logic        wordValidStrobe
);
	logic [3:0] readyRun_reg;
	logic [3:0] readyRun_next;
	// run of ready cycles, saturating, so latency checks skip stalls
	always_comb readyRun_next = !sinkReady ? 4'h0 : (readyRun_reg == 4'hF ? 4'hF : readyRun_reg + 4'h1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			readyRun_reg <= 4'h0;
		else
			readyRun_reg <= readyRun_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_sat; overrangeFlag |-> sampleCodeBits == 10'h3FF; endproperty
	a_sat: assert property (p_sat) else $error("code not saturated");
	property p_hold; !wordValidStrobe |-> $stable(sampleCodeBits) && $stable(overrangeFlag); endproperty
	a_hold: assert property (p_hold) else $error("word moved without strobe");
	property p_hiz; outEnable_n [*7] |-> !overrangeOe; endproperty
	a_hiz: assert property (p_hiz) else $error("pins still driven");
	property p_drive; !outEnable_n [*8] |-> overrangeOe; endproperty
	a_drive: assert property (p_drive) else $error("pins not driven");
	property p_tie; sampleCodeOe == {10{overrangeOe}}; endproperty
	a_tie: assert property (p_tie) else $error("enables split");
	property p_code; readyRun_reg >= 4'hD |->
		{1'b0, sampleCodeBits} == ($past(rawLevel, 13) > 11'h3FF ? 11'h3FF : $past(rawLevel, 13)); endproperty
	a_code: assert property (p_code) else $error("code wrong");
	property p_flag; readyRun_reg >= 4'hD |-> overrangeFlag == ($past(rawLevel, 13) > 11'h3FF); endproperty
	a_flag: assert property (p_flag) else $error("flag wrong");
	property p_strobe; readyRun_reg >= 4'hD |-> wordValidStrobe; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe missing");
	cover property (overrangeFlag && wordValidStrobe);
	cover property (outEnable_n && !overrangeOe);
	cover property (!sinkReady && wordValidStrobe);
endmodule // adc_output_port_props
bind adc_output_port adc_output_port_props adc_output_port_props_i (
	.clk             (clk),
	.arst_n          (arst_n),
	.rawLevel        (rawLevel),
	.outEnable_n     (outEnable_n),
	.sinkReady       (sinkReady),
	.sampleCodeBits  (sampleCodeBits),
	.sampleCodeOe    (sampleCodeOe),
	.overrangeFlag   (overrangeFlag),
	.overrangeOe     (overrangeOe),
	.wordValidStrobe (wordValidStrobe)
);

// ---- sim/host_capture.sv ----
// host capture model latching converter words
`timescale 1ns/1ps
module host_capture (
	// clock, reset, stall request and word pins
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       stall,
	input  wire logic       wordValidStrobe,
	input  wire logic [9:0] sampleCodeBits,
	// handshake and order error count
	output logic            sinkReady,
	output int              badOrder
);
	logic [9:0] lastWord;
	assign sinkReady = !stall;
	// every strobe delivers a word: readiness was granted the clock before
	// each accepted word must be newer than the last one
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			badOrder <= 0;
			lastWord <= 10'h000;
		end else if (wordValidStrobe) begin
			if (lastWord != 10'h000 && sampleCodeBits <= lastWord)
				badOrder <= badOrder + 1;
			lastWord <= sampleCodeBits;
		end
	end
endmodule // host_capture

// ---- sim/tb_top.sv ----
// bench for the converter output port
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [10:0] rawLevel = 11'h000;
	logic        outEnable_n = 1'b0;
	logic        stall = 1'b0;
	logic [9:0]  sampleCodeBits, sampleCodeOe;
	logic        overrangeFlag, overrangeOe, wordValidStrobe, calDone, sinkReady;
	int          badOrder, err_total = 0, compares = 0, n;
	// input level beside expected flag and code
	logic [21:0] rows [6] = '{{11'h000, 11'h000}, {11'h001, 11'h001}, {11'h200, 11'h200},
		{11'h3FF, 11'h3FF}, {11'h400, 11'h7FF}, {11'h7FF, 11'h7FF}};
	adc_output_port adc_output_port_i (
		.clk             (clk),
		.arst_n          (arst_n),
		.rawLevel        (rawLevel),
		.outEnable_n     (outEnable_n),
		.sinkReady       (sinkReady),
		.sampleCodeBits  (sampleCodeBits),
		.sampleCodeOe    (sampleCodeOe),
		.overrangeFlag   (overrangeFlag),
		.overrangeOe     (overrangeOe),
		.wordValidStrobe (wordValidStrobe),
		.calDone         (calDone)
	);
	host_capture host_capture_i (
		.clk             (clk),
		.arst_n          (arst_n),
		.stall           (stall),
		.wordValidStrobe (wordValidStrobe),
		.sampleCodeBits  (sampleCodeBits),
		.sinkReady       (sinkReady),
		.badOrder        (badOrder)
	);
	// free running clock
	initial forever #2 clk = ~clk;
	task automatic check(string what, logic [10:0] seen, logic [10:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#80000;
		err_total++;
		tally_and_finish;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (9999) @(posedge clk);
		#1 check("calDone", calDone, 11'h000);
		@(posedge clk);
		#1 check("calDone", calDone, 11'h001);
		$display("calibration done");
		foreach (rows[i]) begin
			@(posedge clk);
			rawLevel <= rows[i][21:11];
			repeat (15) @(posedge clk);
			#1 check("word", {overrangeFlag, sampleCodeBits}, rows[i][10:0]);
			check("strobe", wordValidStrobe, 11'h001);
		end
		$display("table done");
		@(posedge clk);
		rawLevel <= 11'h155;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (sampleCodeBits !== 10'h155 && n < 30);
		check("latency", 11'(n), 11'h00D);
		@(posedge clk);
		outEnable_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check("oe off", {overrangeOe, sampleCodeOe}, 11'h000);
		@(posedge clk);
		outEnable_n <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check("oe on", {overrangeOe, sampleCodeOe}, 11'h7FF);
		$display("enable done");
		@(posedge clk);
		arst_n <= 1'b0;
		rawLevel <= 11'h000;
		@(posedge clk);
		#1 check("reset", {wordValidStrobe, sampleCodeOe}, 11'h000);
		check("reset word", {overrangeFlag, sampleCodeBits}, 11'h000);
		check("reset cal", calDone, 11'h000);
		@(posedge clk);
		arst_n <= 1'b1;
		for (int k = 1; k < 30; k++) begin
			@(posedge clk);
			rawLevel <= 11'(k);
			stall <= (k >= 10 && k < 20);
		end
		#1 check("order", 11'(badOrder), 11'h000);
		$display("stall done");
		tally_and_finish;
	end
endmodule // tb_top
